// [csio_pkg.sv]
// Package of constants and types for the clocked serial shifter.
package csio_pkg;
    // Register byte addresses: offsets such as 0x1d are not multiples of
    // four, so all are kept as indices and the byte address is four times.
    localparam logic [7:0] CSIO_IDX_MODE = 8'h1c;
    localparam logic [7:0] CSIO_IDX_DATA = 8'h1d;
    localparam logic [7:0] CSIO_IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] CSIO_IDX_IRQ_EN = 8'h21;
    localparam logic [7:0] CSIO_IDX_IRQ_CLR = 8'h22;
    localparam logic [9:0] CSIO_ADDR_MODE = {CSIO_IDX_MODE, 2'b00};
    localparam logic [9:0] CSIO_ADDR_DATA = {CSIO_IDX_DATA, 2'b00};
    localparam logic [9:0] CSIO_ADDR_IRQ_STAT = {CSIO_IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] CSIO_ADDR_IRQ_EN = {CSIO_IDX_IRQ_EN, 2'b00};
    localparam logic [9:0] CSIO_ADDR_IRQ_CLR = {CSIO_IDX_IRQ_CLR, 2'b00};
    // Mode register field positions.
    localparam int CSIO_BIT_DONE = 7;
    localparam int CSIO_BIT_IRQ_EN = 6;
    localparam int CSIO_BIT_CLK_OE = 5;
    localparam int CSIO_BIT_DATA_OE = 4;
    localparam int CSIO_BIT_CKS_HI = 3;
    localparam int CSIO_BIT_CKS_LO = 2;
    localparam int CSIO_BIT_ORDER = 1;
    localparam int CSIO_BIT_START = 0;
    localparam logic [7:0] CSIO_MODE_RESET = 8'h00;
    // Instruction cycle in system clocks, and half shift-clock periods.
    localparam int CSIO_INSTR_CYCLES = 4;
    localparam logic [7:0] CSIO_HALF_X2 = 8'(CSIO_INSTR_CYCLES * 2 / 2);
    localparam logic [7:0] CSIO_HALF_X8 = 8'(CSIO_INSTR_CYCLES * 8 / 2);
    localparam logic [7:0] CSIO_HALF_X32 = 8'(CSIO_INSTR_CYCLES * 32 / 2);
    localparam logic [3:0] CSIO_BITS = 4'h8;
    localparam logic [1:0] CSIO_AXI_OKAY = 2'b00;
    localparam logic [1:0] CSIO_AXI_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        CSIO_CKS_X2,
        CSIO_CKS_X8,
        CSIO_CKS_X32,
        CSIO_CKS_EXT
    } csio_cks_t;
endpackage

// [csio_edge_if.sv]
// Interface carrying the shift-clock edge strobes to the shifter core.
`timescale 1ns/100ps
interface csio_edge_if;
    logic fall;
    logic rise;
    modport src (output fall, output rise);
    modport dst (input fall, input rise);
endinterface

// [csio_clkgen.sv]
// Shift-clock generator: internal divider or synchronised external clock.
`timescale 1ns/100ps
module csio_clkgen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic running,
    input wire logic [1:0] cks,
    input wire logic sck_in,
    output logic sck_int,
    csio_edge_if.src edges
);
    import csio_pkg::*;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [7:0] cnt;
    wire logic external = (cks == 2'(CSIO_CKS_EXT));
    wire logic [7:0] half = (cks == 2'(CSIO_CKS_X2)) ? CSIO_HALF_X2 :
                            (cks == 2'(CSIO_CKS_X8)) ? CSIO_HALF_X8 :
                            CSIO_HALF_X32;
    wire logic wrap = running && !external && (cnt == half - 8'h01);
    // The first stage feeds only the second; edges come from stages two/three.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end else begin
            sync1 <= sck_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    // Equal high and low halves give the 50 percent duty cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn || !running || external) begin
            cnt <= 8'h00;
            sck_int <= 1'b1;
        end else if (wrap) begin
            cnt <= 8'h00;
            sck_int <= !sck_int;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // One strobe per edge of whichever clock is selected.
    assign edges.fall = running && (external ? (sync3 && !sync2)
                                   : (wrap && sck_int));
    assign edges.rise = running && (external ? (!sync3 && sync2)
                                   : (wrap && !sck_int));
endmodule

// [csio_top.sv]
// Eight-bit clock-synchronous serial shifter with an AXI4-Lite slave.
//
// What this block does
// - Writing start bit one begins eight-bit shift.
// - Writing start bit zero halts transfer.
// - Start bit clears itself at transfer end.
// - Eight-bit read/write data register, undefined reset.
// - Output bit changes on shift-clock falling edge.
// - Input bit captured on shift-clock rising edge.
// - Internal clock driven out, 50 percent duty.
// - External clock shifts one bit per pulse.
// - Done flag sets after eight bits; interrupt.
// - External mode output changes at next falling.
// - Clock select: x2, x8, x32, or external.
// - Order bit selects LSB or MSB first.
// - Done flag cleared by writing zero.
// - Enables claim data pin, and clock pin unless the clock is external.
`timescale 1ns/100ps
module csio_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic sin_i,
    output logic sout_o,
    output logic sout_oe,
    output logic irq
);
    import csio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State.
    logic [7:0] mode;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic sin_s1;
    logic sin_s2;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic aw_held;
    logic w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sck_int;
    csio_edge_if edges ();

    ////////////////////////////////////////////////////////////////////////
    // Write decode: address and data may arrive in either order.
    wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_mode = wr_go && aw_addr == CSIO_ADDR_MODE && w_strb[0];
    wire logic wr_data = wr_go && aw_addr == CSIO_ADDR_DATA && w_strb[0];
    wire logic wr_en = wr_go && aw_addr == CSIO_ADDR_IRQ_EN && w_strb[0];
    wire logic wr_clr = wr_go && aw_addr == CSIO_ADDR_IRQ_CLR && w_strb[0];
    wire logic wr_known = aw_addr == CSIO_ADDR_MODE ||
                          aw_addr == CSIO_ADDR_DATA ||
                          aw_addr == CSIO_ADDR_IRQ_EN ||
                          aw_addr == CSIO_ADDR_IRQ_CLR;
    wire logic [7:0] wbyte = w_data[7:0];
    wire logic running = mode[CSIO_BIT_START];
    wire logic msb_first = mode[CSIO_BIT_ORDER];
    wire logic [1:0] cks = mode[CSIO_BIT_CKS_HI:CSIO_BIT_CKS_LO];
    wire logic last_bit = edges.rise && bitcnt == CSIO_BITS - 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // Shift-clock source.
    csio_clkgen u_clkgen (
        .aclk(aclk),
        .aresetn(aresetn),
        .running(running),
        .cks(cks),
        .sck_in(sck_i),
        .sck_int(sck_int),
        .edges(edges)
    );

    // Serial input synchroniser.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sin_s1 <= 1'b0;
            sin_s2 <= 1'b0;
        end else begin
            sin_s1 <= sin_i;
            sin_s2 <= sin_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register. Done flag: hardware set wins over a clearing write.
    wire logic [7:0] next_mode_wr = {
        mode[CSIO_BIT_DONE] & wbyte[CSIO_BIT_DONE],
        wbyte[6:0]};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= CSIO_MODE_RESET;
        end else begin
            if (wr_mode) begin
                mode <= next_mode_wr;
            end
            if (last_bit) begin
                mode[CSIO_BIT_START] <= 1'b0;
                mode[CSIO_BIT_DONE] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift register, no reset. Rising edge shifts the new bit in at the end
    // opposite the outgoing bit; the pin follows on the falling edge.
    wire logic [7:0] next_shift = msb_first ? {shreg[6:0], sin_s2}
                                            : {sin_s2, shreg[7:1]};
    always_ff @(posedge aclk) begin
        if (wr_data) begin
            shreg <= wbyte;
        end else if (edges.rise) begin
            shreg <= next_shift;
        end
    end

    // Bit counter, restarted whenever the shifter is idle.
    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            bitcnt <= 4'h0;
        end else if (edges.rise) begin
            bitcnt <= bitcnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins. Output data moves only on a falling edge, even after a load.
    wire logic out_bit = msb_first ? shreg[7] : shreg[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sout_o <= 1'b1;
            sck_o <= 1'b1;
            sck_oe <= 1'b0;
            sout_oe <= 1'b0;
        end else begin
            if (edges.fall) begin
                sout_o <= out_bit;
            end
            sck_o <= sck_int;
            sck_oe <= mode[CSIO_BIT_CLK_OE] && cks != 2'(CSIO_CKS_EXT);
            sout_oe <= mode[CSIO_BIT_DATA_OE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: bit0 transfer done, bit1 transfer halted by write.
    wire logic halted = wr_mode && running && !wbyte[CSIO_BIT_START];
    wire logic [1:0] events = {halted, last_bit};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 2'b00;
            irq_en <= 2'b00;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_clr ? wbyte[1:0] : 2'b00)) | events;
            if (wr_en) begin
                irq_en <= wbyte[1:0];
            end
            irq <= |(irq_stat & irq_en) ||
                   (mode[CSIO_BIT_DONE] && mode[CSIO_BIT_IRQ_EN]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI write channels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CSIO_AXI_OKAY;
            aw_addr <= 10'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[9:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? CSIO_AXI_OKAY : CSIO_AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read channel; answer registered one cycle after the address.
    wire logic [9:0] ra = {s_axi_araddr[9:2], 2'b00};
    wire logic rd_known = ra == CSIO_ADDR_MODE || ra == CSIO_ADDR_DATA ||
                          ra == CSIO_ADDR_IRQ_STAT || ra == CSIO_ADDR_IRQ_EN ||
                          ra == CSIO_ADDR_IRQ_CLR;
    wire logic [7:0] rd_byte = (ra == CSIO_ADDR_MODE) ? mode :
                               (ra == CSIO_ADDR_DATA) ? shreg :
                               (ra == CSIO_ADDR_IRQ_STAT) ? {6'h00, irq_stat} :
                               (ra == CSIO_ADDR_IRQ_EN) ? {6'h00, irq_en} :
                               8'h00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CSIO_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_known ? CSIO_AXI_OKAY : CSIO_AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready outputs, registered as the next cycle's idle condition. They
    // keep the timing of a decode of the state flops, but every pin of the
    // block now leaves from a flop.
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic next_aw_held = !wr_go && (aw_held || aw_take);
    wire logic next_w_held = !wr_go && (w_held || w_take);
    wire logic next_bvalid = wr_go || (s_axi_bvalid && !s_axi_bready);
    wire logic next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            s_axi_arready <= !next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_start_clears: assert property (@(posedge aclk)
        disable iff (!aresetn)
        last_bit |=> !mode[CSIO_BIT_START] && mode[CSIO_BIT_DONE])
        else $error("start bit not cleared at transfer end");
    a_done_sets: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(mode[CSIO_BIT_DONE]) |-> $past(bitcnt) == 4'h7)
        else $error("done flag set before eight bits");
    a_irq_follows: assert property (@(posedge aclk)
        disable iff (!aresetn)
        mode[CSIO_BIT_DONE] && mode[CSIO_BIT_IRQ_EN] |=> irq)
        else $error("interrupt missing for enabled done flag");
    a_out_on_fall: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $changed(sout_o) |-> $past(edges.fall))
        else $error("serial output moved off a falling edge");
    a_halt_stops: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_mode && !wbyte[CSIO_BIT_START] |=> !running ##1 bitcnt == 4'h0)
        else $error("write of zero did not halt transfer");
    a_start_runs: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_mode && wbyte[CSIO_BIT_START] && !last_bit |=> running)
        else $error("write of one did not start transfer");
    a_capture_rise: assert property (@(posedge aclk)
        disable iff (!aresetn)
        edges.rise && !wr_data && !msb_first |=> shreg[7] == $past(sin_s2))
        else $error("input bit not captured on rising edge");
    a_done_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_mode && !wbyte[CSIO_BIT_DONE] && !last_bit
        |=> !mode[CSIO_BIT_DONE])
        else $error("done flag not cleared by zero write");
    a_clk_oe: assert property (@(posedge aclk)
        disable iff (!aresetn)
        mode[CSIO_BIT_CLK_OE] && cks != 2'(CSIO_CKS_EXT) |=> sck_oe)
        else $error("clock pin not driven");
    c_transfer_done: cover property (@(posedge aclk) last_bit);
    c_ext_mode: cover property (@(posedge aclk)
        cks == 2'(CSIO_CKS_EXT) && edges.rise);
    c_halted: cover property (@(posedge aclk) halted);
    c_msb_done: cover property (@(posedge aclk) last_bit && msb_first);
endmodule

// [csio_partner.sv]
// Behavioural model of the far-side clocked serial device.
`timescale 1ns/100ps
module csio_partner (
    input wire logic sck,
    input wire logic sout,
    input wire logic msb_first,
    input wire logic [7:0] tx,
    input wire logic arm,
    input wire logic ext_run,
    output logic sck_drv,
    output logic sin,
    output logic [7:0] rx,
    output logic [3:0] nbits
);
    int idx;
    ////////////////////////////////////////////////////////////////////////
    // Idle state: clock parked high, no frame in progress.
    initial begin
        sck_drv = 1'b1;
        sin = 1'b0;
        rx = 8'h00;
        nbits = 4'h0;
        idx = 8;
    end
    // A new frame forgets the old one; the line flips so no stale bit passes.
    always @(posedge arm) begin
        idx = 0;
        rx = 8'h00;
        nbits = 4'h0;
        sin = ~sin;
    end
    // Eight pulses at 125 ns, well below the half-rate ceiling of the pin.
    always @(posedge ext_run) begin
        #7.3;
        repeat (8) begin
            #62.5 sck_drv = 1'b0;
            #62.5 sck_drv = 1'b1;
        end
    end
    // Our data changes on the falling edge so it is settled at the rise.
    always @(negedge sck) begin
        if (idx < 8) begin
            sin = msb_first ? tx[7 - idx] : tx[idx];
            idx = idx + 1;
        end else begin
            sin = ~sin;
        end
    end
    // The device's output is sampled on the rising edge, in frame order.
    always @(posedge sck) begin
        if (nbits < 4'h8) begin
            rx = msb_first ? {rx[6:0], sout} : {sout, rx[7:1]};
            nbits = nbits + 4'h1;
        end
    end
endmodule

// [csio_top_tb_top.sv]
// Self-checking bench for the clocked serial shifter.
`timescale 1ns/100ps
module csio_top_tb_top;
    import csio_pkg::*;
    `define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, s0;
    logic sck_o, sck_oe, sout_o, sout_oe, irq, sck_drv, sin, arm, ext_run, msb;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb, nbits;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] ptx, prx, lo_cnt, hi_cnt, lo_last, hi_last, dx;
    int err_count, checked, n;
    // With the pin released the partner owns the clock; data has no pull.
    wire logic sck_pin = sck_oe ? sck_o : sck_drv;
    wire logic sout_pin = sout_oe ? sout_o : ~sout_o;
    csio_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sck_i(sck_pin), .sck_o(sck_o),
        .sck_oe(sck_oe), .sin_i(sin), .sout_o(sout_o), .sout_oe(sout_oe),
        .irq(irq));
    csio_partner peer (.sck(sck_pin), .sout(sout_pin), .msb_first(msb),
        .tx(ptx), .arm(arm), .ext_run(ext_run), .sck_drv(sck_drv),
        .sin(sin), .rx(prx), .nbits(nbits));
    ////////////////////////////////////////////////////////////////////////
    // Free-running 250 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // Length of each phase of the driven shift clock, in aclk cycles.
    always @(posedge aclk) begin
        if (sck_oe === 1'b1 && sck_o === 1'b0) begin
            lo_cnt <= lo_cnt + 8'h01;
            if (hi_cnt != 8'h00)
                hi_last <= hi_cnt;
            hi_cnt <= 8'h00;
        end else if (sck_oe === 1'b1) begin
            hi_cnt <= hi_cnt + 8'h01;
            if (lo_cnt != 8'h00)
                lo_last <= lo_cnt;
            lo_cnt <= 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("Counts: %0d mismatches in %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Waits c edges, then half a cycle so registered outputs have settled.
    task automatic idle(input int c);
        repeat (c) @(posedge aclk);
        @(negedge aclk);
    endtask
    // Write: address and data offered together, each dropped once taken.
    task automatic axi_wr(input logic [9:0] a, input logic [7:0] d);
        logic aw_go, w_go, aw_hit, w_hit;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_go = 1'b0;
        w_go = 1'b0;
        while (!(aw_go && w_go)) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready === 1'b1;
            w_hit = s_axi_wvalid && s_axi_wready === 1'b1;
            @(posedge aclk);
            if (aw_hit)
                s_axi_awvalid <= 1'b0;
            if (w_hit)
                s_axi_wvalid <= 1'b0;
            aw_go = aw_go || aw_hit;
            w_go = w_go || w_hit;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    // Read: the answer lands in v and resp.
    task automatic axi_rd(input logic [9:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // Polling the start bit also guards each new start in run_int against overlap.
    task automatic wait_stopped();
        do axi_rd(CSIO_ADDR_MODE); while (v[CSIO_BIT_START] !== 1'b0);
    endtask
    task automatic start_partner(input logic [7:0] p, input logic ord);
        @(posedge aclk);
        ptx <= p;
        msb <= ord;
        arm <= 1'b1;
        @(posedge aclk);
        arm <= 1'b0;
    endtask
    // One internal-clock frame in each rate and bit order.
    task automatic run_int(input logic [1:0] cks, input logic ord,
            input logic [7:0] d, input logic [7:0] p);
        logic [7:0] half;
        half = cks == 2'd0 ? CSIO_HALF_X2 :
            cks == 2'd1 ? CSIO_HALF_X8 : CSIO_HALF_X32;
        wait_stopped();
        start_partner(p, ord);
        axi_wr(CSIO_ADDR_DATA, d);
        axi_wr(CSIO_ADDR_MODE, {4'h3, cks, ord, 1'b1});
        idle(2);
        `CHK({sck_oe, sout_oe}, 2'b11)
        wait_stopped();
        `CHK(prx, d)
        `CHK(nbits, 4'h8)
        `CHK(lo_last, half)
        `CHK(hi_last, half)
        axi_rd(CSIO_ADDR_DATA);
        `CHK(v[7:0], p)
        axi_rd(CSIO_ADDR_MODE);
        `CHK(v[CSIO_BIT_DONE], 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog, ten times the expected length of the run.
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
    // Main sequence.
    initial begin
        {err_count, checked, lo_cnt, hi_cnt, lo_last, hi_last} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, arm, ext_run, msb, ptx} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CSIO_ADDR_MODE);
        `CHK(v[7:0], CSIO_MODE_RESET)
        idle(0);
        `CHK({sck_oe, sout_oe, irq}, 3'b000)
        axi_rd(10'h3fc);
        `CHK({resp, v}, {CSIO_AXI_SLVERR, 32'h00000000})
        axi_wr(10'h3fc, 8'h5a);
        `CHK(resp, CSIO_AXI_SLVERR)
        for (int i = 0; i < 6; i++)
            run_int(2'(i % 3), 1'(i / 3), 8'hc5 ^ 8'(i * 17), 8'h3a + 8'(i));
        // Interrupt through the mode bits, then through status and enable.
        idle(0);
        `CHK(irq, 1'b0)
        axi_wr(CSIO_ADDR_MODE, 8'hc0);
        idle(1);
        `CHK(irq, 1'b1)
        axi_rd(CSIO_ADDR_MODE);
        `CHK(v[7:0], 8'hc0)
        axi_wr(CSIO_ADDR_MODE, 8'h40);
        idle(1);
        `CHK(irq, 1'b0)
        axi_rd(CSIO_ADDR_IRQ_STAT);
        `CHK(v[0], 1'b1)
        axi_wr(CSIO_ADDR_IRQ_EN, 8'h01);
        idle(1);
        `CHK(irq, 1'b1)
        axi_wr(CSIO_ADDR_IRQ_CLR, 8'h01);
        idle(1);
        `CHK(irq, 1'b0)
        // Halt in mid-frame; 1200 cycles would otherwise finish it.
        start_partner(8'h96, 1'b0);
        axi_wr(CSIO_ADDR_MODE, 8'h39);
        idle(300);
        axi_wr(CSIO_ADDR_MODE, 8'h38);
        idle(900);
        `CHK(nbits < 4'h8, 1'b1)
        axi_rd(CSIO_ADDR_MODE);
        `CHK({v[CSIO_BIT_DONE], v[CSIO_BIT_START]}, 2'b00)
        axi_rd(CSIO_ADDR_IRQ_STAT);
        `CHK(v[1], 1'b1)
        axi_wr(CSIO_ADDR_IRQ_CLR, 8'h03);
        // External clock: output must hold until the first falling edge.
        // The first bit to go out is the inverse of the pin's present level,
        // so a pin that followed the load at once would be seen.
        start_partner(8'h6b, 1'b1);
        idle(0);
        s0 = sout_o;
        dx = {~s0, 7'h52};
        axi_wr(CSIO_ADDR_DATA, dx);
        axi_wr(CSIO_ADDR_MODE, 8'h1f);
        idle(2);
        `CHK(sck_oe, 1'b0)
        n = 0;
        repeat (20) begin
            @(negedge aclk);
            if (sout_o !== s0)
                n++;
        end
        `CHK(n, 0)
        @(posedge aclk);
        ext_run <= 1'b1;
        wait_stopped();
        `CHK(prx, dx)
        `CHK(nbits, 4'h8)
        axi_rd(CSIO_ADDR_DATA);
        `CHK(v[7:0], 8'h6b)
        ext_run <= 1'b0;
        complete_run();
    end
endmodule
